// ---- hdl/spl_link.sv ----
// Purpose: Programming link, default lock, write lock and supply overrides
// Assumes: srst is the supply power-on reset; comparators are asynchronous
// Notes:   Memory storage lives outside; this block drives its port
//
// What this block does
// - Power-on reset puts the output pin in high impedance.
// - Low-supply detection is on after reset, off when its disable bit is 1.
// - In SENT mode a low supply sets a SENT status bit.
// - Outside SENT mode a low supply forces the output low.
// - Select bit picks high or low overvoltage trip level.
// - Overvoltage grounds PWM output, or sets SENT status in SENT mode.
// - All memory reads and writes are refused until the lock opens.
// - Access code written to 0x24 in time opens the lock.
// - Missing the power-up window blocks access for the whole session.
// - Every power cycle re-arms the default lock.
// - Active write lock refuses writes and access-code unlocking.
// - Active write lock also blocks reads, as the lock never opens.
// - Mid-bit rising edge is 0, falling edge is 1.
// - Address and data are sent most significant bit first.
// - Device only transmits in answer to a controller command.
// - Decode read, write, access-code, output disable and enable.
// - Only a read gets an answer, a read-acknowledge frame.
// - Commands arrive on supply; answers leave on the output pin.
// - Writes commit only after two programming pulses on the output.
// - Only a device seeing programming pulses accepts the write.
// - Three-bit CRC x^3+x+1, preset 111, over command, address and data bits; answer CRC over data bits only.
// - Normal output is off from read command until the answer ends.
// - Bit rate follows the controller, 4 to 100 kbps.
`include "spl_params.svh"
`timescale 1ns/1ps
`default_nettype none

module spl_link #(
  parameter int                      PW              = 17,
  parameter int                      ACC_TIMEOUT_CYC = `SPL_ACC_TIMEOUT_CYC,
  // Arbitrary value, not taken from any part
  parameter logic [`SPL_CODE_W-1:0]  ACCESS_CODE     = 30'h0a5c3e17
) (
  input  wire logic                   clk_sys,
  input  wire logic                   srst,
  input  wire logic                   ce,
  input  wire logic                   vcc_man_in,
  input  wire logic                   prog_pulse_in,
  input  wire logic                   low_supply_detect,
  input  wire logic                   ov_high_in,
  input  wire logic                   ov_low_in,
  input  wire logic                   sent_mode,
  input  wire logic                   norm_out,
  input  wire logic                   low_supply_detect_disable,
  input  wire logic                   overvoltage_level_low_select,
  input  wire logic                   permanent_write_lock,
  input  wire logic [`SPL_DATA_W-1:0] mem_rdata,
  output logic                        out_o,
  output logic                        out_oe,
  output logic                        sent_lsd_flag,
  output logic                        sent_ov_flag,
  output logic [5:0]                  mem_addr,
  output logic [`SPL_DATA_W-1:0]      mem_wdata,
  output logic                        mem_we,
  output logic                        mem_re,
  output logic                        unlocked,
  output logic                        access_expired
);

  localparam int AW = $clog2(ACC_TIMEOUT_CYC + 1);

  logic [4:0]             s1_r;
  logic [4:0]             s2_r;
  logic                   man_d_r;
  logic                   prog_d_r;
  logic                   init_r;
  logic                   wlock_r;
  logic                   unlock_r;
  logic                   expired_r;
  logic [AW-1:0]          acc_cnt_r;
  spl_pkg::spl_rx_t       rx_st_r;
  logic [PW-1:0]          tmr_r;
  logic [PW-1:0]          per_r;
  logic [5:0]             rx_n_r;
  logic [43:0]            rx_sh_r;
  logic [2:0]             rx_crc_r;
  logic                   rx_done_r;
  logic                   rx_ok_r;
  logic                   rx_long_r;
  spl_pkg::spl_cm_t       cm_st_r;
  logic                   acc_ok_r;
  logic                   outdis_r;
  logic                   pcnt_r;
  logic [15:0]            gap_r;
  logic [36:0]            tx_sh_r;
  logic [5:0]             tx_n_r;
  logic                   tx_half_r;
  logic [PW-1:0]          tx_tmr_r;
  logic                   man;
  logic                   rise;
  logic                   fall;
  logic                   p_fall;
  logic                   lsd_act;
  logic                   ov_act;
  logic [2:0]             crc_nxt;
  logic [5:0]             rx_n_nxt;
  logic [2:0]             cmd_w;
  logic [5:0]             addr_w;
  logic [`SPL_DATA_W-1:0] data_w;

  // CRC x^3+x+1, one bit per step
  function automatic logic [2:0] spl_crc_step(input logic [2:0] c, input logic b);
    logic fb;
    fb = c[2] ^ b;
    return {c[1], c[0] ^ fb, fb};
  endfunction

  // CRC of a whole data word, MSB first
  function automatic logic [2:0] spl_crc_word(input logic [`SPL_DATA_W-1:0] d);
    logic [2:0] c;
    c = `SPL_CRC_INIT;
    for (int i = `SPL_DATA_W - 1; i >= 0; i--) begin
      c = spl_crc_step(c, d[i]);
    end
    return c;
  endfunction

  //--------------------------------------------------------------
  // Input synchronisers and edges
  //--------------------------------------------------------------
  // Two flops on every asynchronous comparator input
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s1_r     <= 5'h00;
      s2_r     <= 5'h00;
      man_d_r  <= 1'b0;
      prog_d_r <= 1'b0;
    end else if (ce) begin
      s1_r     <= {vcc_man_in, prog_pulse_in, low_supply_detect, ov_high_in, ov_low_in};
      s2_r     <= s1_r;
      man_d_r  <= s2_r[4];
      prog_d_r <= s2_r[3];
    end
  end

  // Edge and condition terms
  assign man     = s2_r[4];
  assign rise    = man & ~man_d_r;
  assign fall    = ~man & man_d_r;
  assign p_fall  = ~s2_r[3] & prog_d_r;
  assign lsd_act = s2_r[2] & ~low_supply_detect_disable;
  assign ov_act  = overvoltage_level_low_select ? s2_r[0] : s2_r[1];
  assign crc_nxt = spl_crc_step(rx_crc_r, fall);
  assign rx_n_nxt = rx_n_r + 6'h01;
  assign cmd_w   = rx_long_r ? rx_sh_r[`SPL_LW_CMD] : rx_sh_r[`SPL_SH_CMD];
  assign addr_w  = rx_long_r ? rx_sh_r[`SPL_LW_ADDR] : rx_sh_r[`SPL_SH_ADDR];
  assign data_w  = rx_sh_r[`SPL_LW_DATA];

  //--------------------------------------------------------------
  // Power session: lock window and write lock
  //--------------------------------------------------------------
  // Write lock caught once after reset release; lock re-armed by reset
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      init_r   <= 1'b0;
      wlock_r  <= 1'b0;
      unlock_r <= 1'b0;
    end else if (ce) begin
      if (!init_r) begin
        init_r  <= 1'b1;
        wlock_r <= permanent_write_lock;
      end
      if (acc_ok_r) begin
        unlock_r <= 1'b1;
      end
    end
  end

  // Access window timer from power-up
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      acc_cnt_r <= '0;
      expired_r <= 1'b0;
    end else if (ce && !expired_r) begin
      if (acc_cnt_r == AW'(ACC_TIMEOUT_CYC - 1)) begin
        expired_r <= 1'b1;
      end else begin
        acc_cnt_r <= acc_cnt_r + 1'b1;
      end
    end
  end

  //--------------------------------------------------------------
  // Manchester receiver on the supply line
  //--------------------------------------------------------------
  // Sync measures the period; mid-bit edges sampled after 3/4 period
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rx_st_r   <= spl_pkg::RX_IDLE;
      tmr_r     <= '0;
      per_r     <= '0;
      rx_n_r    <= 6'h00;
      rx_sh_r   <= 44'h0;
      rx_crc_r  <= `SPL_CRC_INIT;
      rx_done_r <= 1'b0;
      rx_ok_r   <= 1'b0;
      rx_long_r <= 1'b0;
    end else if (ce) begin
      rx_done_r <= 1'b0;
      if (!(&tmr_r)) begin
        tmr_r <= tmr_r + 1'b1;
      end
      unique case (rx_st_r)
        spl_pkg::RX_IDLE: begin
          if (rise) begin
            tmr_r   <= '0;
            rx_st_r <= spl_pkg::RX_MEAS;
          end
        end
        spl_pkg::RX_MEAS: begin
          if (rise) begin
            per_r    <= tmr_r + 1'b1;
            tmr_r    <= '0;
            rx_n_r   <= 6'h00;
            rx_crc_r <= `SPL_CRC_INIT;
            rx_st_r  <= spl_pkg::RX_BITS;
          end else if (&tmr_r) begin
            rx_st_r <= spl_pkg::RX_IDLE;
          end
        end
        spl_pkg::RX_BITS: begin
          if ((rise || fall) && tmr_r >= per_r - (per_r >> 2)) begin
            rx_sh_r  <= {rx_sh_r[42:0], fall};
            rx_crc_r <= crc_nxt;
            rx_n_r   <= rx_n_nxt;
            tmr_r    <= '0;
            if ((rx_n_nxt == `SPL_RX_LEN_SH && rx_sh_r[`SPL_SH_CMD_EARLY] != `SPL_CMD_WRITE) ||
                rx_n_nxt == `SPL_RX_LEN_WR) begin
              rx_done_r <= 1'b1;
              rx_ok_r   <= (crc_nxt == 3'h0);
              rx_long_r <= (rx_n_nxt == `SPL_RX_LEN_WR);
              rx_st_r   <= spl_pkg::RX_IDLE;
            end
          end else if (tmr_r > per_r + (per_r >> 2)) begin
            rx_st_r <= spl_pkg::RX_IDLE;
          end
        end
      endcase
    end
  end

  //--------------------------------------------------------------
  // Command handling, write commit and read answer
  //--------------------------------------------------------------
  // Decode, programming pulse count, read gap and Manchester transmit
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cm_st_r   <= spl_pkg::CM_IDLE;
      acc_ok_r  <= 1'b0;
      outdis_r  <= 1'b0;
      pcnt_r    <= 1'b0;
      gap_r     <= 16'h0000;
      tx_sh_r   <= 37'h0;
      tx_n_r    <= 6'h00;
      tx_half_r <= 1'b0;
      tx_tmr_r  <= '0;
      mem_addr  <= 6'h00;
      mem_wdata <= '0;
      mem_we    <= 1'b0;
      mem_re    <= 1'b0;
    end else if (ce) begin
      mem_we   <= 1'b0;
      mem_re   <= 1'b0;
      acc_ok_r <= 1'b0;
      unique case (cm_st_r)
        spl_pkg::CM_IDLE, spl_pkg::CM_PULSE: begin
          if (cm_st_r == spl_pkg::CM_PULSE && p_fall) begin
            pcnt_r <= 1'b1;
            if (pcnt_r) begin
              mem_we  <= 1'b1;
              cm_st_r <= spl_pkg::CM_IDLE;
            end
          end
          if (rx_done_r && rx_ok_r) begin
            cm_st_r <= spl_pkg::CM_IDLE;
            case (cmd_w)
              `SPL_CMD_READ: begin
                if (unlock_r) begin
                  mem_addr <= addr_w;
                  mem_re   <= 1'b1;
                  gap_r    <= 16'h0000;
                  cm_st_r  <= spl_pkg::CM_GAP;
                end
              end
              `SPL_CMD_WRITE: begin
                if (rx_long_r && addr_w == `SPL_ADDR_ACCESS &&
                    data_w[`SPL_CODE_W-1:0] == ACCESS_CODE) begin
                  acc_ok_r <= !expired_r && !wlock_r;
                end else if (rx_long_r && unlock_r && !wlock_r) begin
                  mem_addr  <= addr_w;
                  mem_wdata <= data_w;
                  pcnt_r    <= 1'b0;
                  cm_st_r   <= spl_pkg::CM_PULSE;
                end
              end
              `SPL_CMD_OUT_DIS: begin
                if (unlock_r) begin
                  outdis_r <= 1'b1;
                end
              end
              `SPL_CMD_OUT_EN: begin
                if (unlock_r) begin
                  outdis_r <= 1'b0;
                end
              end
              default: begin
              end
            endcase
          end
        end
        spl_pkg::CM_GAP: begin
          gap_r <= gap_r + 16'h0001;
          if (gap_r == 16'(`SPL_READ_GAP_CYC - 1)) begin
            tx_sh_r   <= {`SPL_TX_SYNC, mem_rdata, spl_crc_word(mem_rdata)};
            tx_n_r    <= 6'h00;
            tx_half_r <= 1'b0;
            tx_tmr_r  <= '0;
            cm_st_r   <= spl_pkg::CM_TX;
          end
        end
        spl_pkg::CM_TX: begin
          tx_tmr_r <= tx_tmr_r + 1'b1;
          if (tx_tmr_r >= (per_r >> 1) - 1'b1) begin
            tx_tmr_r  <= '0;
            tx_half_r <= ~tx_half_r;
            if (tx_half_r) begin
              tx_sh_r <= {tx_sh_r[35:0], 1'b0};
              tx_n_r  <= tx_n_r + 6'h01;
              if (tx_n_r == `SPL_TX_LAST) begin
                cm_st_r <= spl_pkg::CM_IDLE;
              end
            end
          end
        end
      endcase
    end
  end

  //--------------------------------------------------------------
  // Output pin and SENT status
  //--------------------------------------------------------------
  // Answer frame first, then read gap held low, then disables, then supply overrides
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      out_o         <= 1'b0;
      out_oe        <= 1'b0;
      sent_lsd_flag <= 1'b0;
      sent_ov_flag  <= 1'b0;
    end else if (ce) begin
      sent_lsd_flag <= sent_mode & lsd_act;
      sent_ov_flag  <= sent_mode & ov_act;
      if (cm_st_r == spl_pkg::CM_TX) begin
        out_oe <= 1'b1;
        out_o  <= tx_half_r ? ~tx_sh_r[36] : tx_sh_r[36];
      end else if (cm_st_r == spl_pkg::CM_GAP) begin
        out_oe <= 1'b1;
        out_o  <= 1'b0;
      end else if (outdis_r || cm_st_r == spl_pkg::CM_PULSE) begin
        out_oe <= 1'b0;
        out_o  <= 1'b0;
      end else if (!sent_mode && (ov_act || lsd_act)) begin
        out_oe <= 1'b1;
        out_o  <= 1'b0;
      end else begin
        out_oe <= 1'b1;
        out_o  <= norm_out;
      end
    end
  end

  // Status straight from the session flops
  assign unlocked       = unlock_r;
  assign access_expired = expired_r;

  //--------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------
  default clocking spl_cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  sequence s_read_cmd;
    ce && rx_done_r && rx_ok_r && !rx_long_r && cmd_w == `SPL_CMD_READ &&
    unlock_r && cm_st_r == spl_pkg::CM_IDLE;
  endsequence
  sequence s_ce_next;
    ce;
  endsequence

  property p_reset_hiz;
    $past(srst) |-> !out_oe;
  endproperty
  a_reset_hiz: assert property (p_reset_hiz) else $error("Output driven right after reset");

  property p_locked_no_access;
    !unlock_r |-> !mem_we && !mem_re;
  endproperty
  a_locked_no_access: assert property (p_locked_no_access) else $error("Memory access while locked");

  property p_wlock_no_write;
    wlock_r |-> !mem_we;
  endproperty
  a_wlock_no_write: assert property (p_wlock_no_write) else $error("Write under write lock");

  property p_expired_stays_locked;
    expired_r && !unlock_r && !acc_ok_r |=> !unlock_r;
  endproperty
  a_expired_stays_locked: assert property (p_expired_stays_locked) else $error("Unlock after window");

  property p_read_holds_low;
    s_read_cmd ##1 s_ce_next |=> cm_st_r == spl_pkg::CM_GAP && out_oe && !out_o;
  endproperty
  a_read_holds_low: assert property (p_read_holds_low) else $error("Read did not hold output low");

  property p_lsd_forces_low;
    ce && cm_st_r == spl_pkg::CM_IDLE && !outdis_r && !sent_mode && lsd_act |=> out_oe && !out_o;
  endproperty
  a_lsd_forces_low: assert property (p_lsd_forces_low) else $error("Low supply did not force low");

  property p_ov_grounds;
    ce && cm_st_r == spl_pkg::CM_IDLE && !outdis_r && !sent_mode && ov_act |=> out_oe && !out_o;
  endproperty
  a_ov_grounds: assert property (p_ov_grounds) else $error("Overvoltage did not ground output");

  property p_sent_lsd;
    ce && sent_mode && s2_r[2] && !low_supply_detect_disable |=> sent_lsd_flag;
  endproperty
  a_sent_lsd: assert property (p_sent_lsd) else $error("SENT low supply bit missing");

  property p_bad_crc_ignored;
    rx_done_r && !rx_ok_r && cm_st_r == spl_pkg::CM_IDLE |=> cm_st_r == spl_pkg::CM_IDLE && !acc_ok_r;
  endproperty
  a_bad_crc_ignored: assert property (p_bad_crc_ignored) else $error("Bad CRC frame acted on");

  property p_tx_only_after_gap;
    $rose(cm_st_r == spl_pkg::CM_TX) |-> $past(cm_st_r) == spl_pkg::CM_GAP;
  endproperty
  a_tx_only_after_gap: assert property (p_tx_only_after_gap) else $error("Transmit without read");

endmodule

`default_nettype wire

// ---- hdl/spl_params.svh ----
// Purpose: Constants of the sensor programming link and lock logic
// Assumes: 100 MHz system clock
// Notes:   Frame layout: 2 sync bits, 3 cmd, 6 addr, [32 data], 3 crc
`ifndef SPL_PARAMS_SVH
`define SPL_PARAMS_SVH
`define SPL_CLK_MHZ        100
`define SPL_ACC_TIMEOUT_MS 70
`define SPL_ACC_TIMEOUT_CYC (`SPL_ACC_TIMEOUT_MS * 1000 * `SPL_CLK_MHZ)
`define SPL_READ_GAP_US    30
`define SPL_READ_GAP_CYC   (`SPL_READ_GAP_US * `SPL_CLK_MHZ)
`define SPL_ADDR_ACCESS    6'h24
`define SPL_CODE_W         30
`define SPL_DATA_W         32
`define SPL_CMD_READ       3'h0
`define SPL_CMD_WRITE      3'h1
`define SPL_CMD_OUT_DIS    3'h2
`define SPL_CMD_OUT_EN     3'h3
`define SPL_CRC_INIT       3'h7
`define SPL_RX_LEN_SH      6'h0c
`define SPL_RX_LEN_WR      6'h2c
`define SPL_TX_LAST        6'h24
`define SPL_TX_SYNC        2'h0
`define SPL_LW_CMD         43:41
`define SPL_LW_ADDR        40:35
`define SPL_LW_DATA        34:3
`define SPL_SH_CMD         11:9
`define SPL_SH_CMD_EARLY   10:8
`define SPL_SH_ADDR        8:3
`endif

// ---- hdl/spl_pkg.sv ----
// Purpose: Types of the sensor programming link and lock logic
// Assumes: Nothing
// Notes:   State machine encodings only
package spl_pkg;
  typedef enum logic [1:0] {RX_IDLE, RX_MEAS, RX_BITS} spl_rx_t;
  typedef enum logic [1:0] {CM_IDLE, CM_PULSE, CM_GAP, CM_TX} spl_cm_t;
endpackage

// ---- testbench/spl_ctl_model.sv ----
// Purpose: External controller model for the programming link
// Assumes: Supply line idles low; called at a rising clock edge
// Notes:   Bit period is set by the caller through per
`timescale 1ns/1ps
`default_nettype none
module spl_ctl_model (
  input  wire logic        clk_sys,
  input  wire logic        out_o,
  output logic             vcc_man,
  output logic             prog_pulse,
  output logic [31:0]      rd_word,
  output logic             rd_done
);
  // ----------------------------------------
  // Frame generation and answer capture
  // ----------------------------------------
  int per = 64;
  initial begin
    vcc_man = 1'b0;
    prog_pulse = 1'b0;
    rd_word = 32'h0;
    rd_done = 1'b0;
  end
  // One bit: first half the bit, second half its inverse
  task automatic mbit(input logic b);
    vcc_man <= b;
    repeat (per / 2) @(posedge clk_sys);
    vcc_man <= ~b;
    repeat (per - per / 2) @(posedge clk_sys);
  endtask
  // Command frame: two sync zeros, fields MSB first, then CRC
  task automatic send(input logic [2:0] cmd, input logic [5:0] adr, input logic [31:0] dat, input logic bad);
    logic [40:0] f;
    logic [2:0]  c;
    logic        fb;
    int          lo;
    f = {cmd, adr, dat};
    lo = (cmd == 3'h1) ? 0 : 32;
    c = 3'h7;
    mbit(1'b0);
    mbit(1'b0);
    for (int i = 40; i >= lo; i--) begin
      mbit(f[i]);
      fb = c[2] ^ f[i];
      c = {c[1], c[0] ^ fb, fb};
    end
    c[0] = c[0] ^ bad;
    for (int i = 2; i >= 0; i--) begin
      mbit(c[i]);
    end
    vcc_man <= 1'b0;
    repeat (2 * per) @(posedge clk_sys);
  endtask
  // Two programming pulses on the output line
  task automatic pulses();
    repeat (2) begin
      prog_pulse <= 1'b1;
      repeat (per) @(posedge clk_sys);
      prog_pulse <= 1'b0;
      repeat (per) @(posedge clk_sys);
    end
  endtask
  // Decode a read answer: bit value is the inverse of its second half
  task automatic getans();
    logic [32:0] w;
    w = 33'h0;
    repeat (200) @(posedge clk_sys);
    @(posedge out_o);
    repeat (per / 4) @(posedge clk_sys);
    for (int k = 1; k <= 33; k++) begin
      repeat (per) @(posedge clk_sys);
      w = {w[31:0], ~out_o};
    end
    rd_word <= w[31:0];
    rd_done <= 1'b1;
    @(posedge clk_sys);
    rd_done <= 1'b0;
    // Let the answer and its CRC end before the next command
    repeat (6 * per) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// ---- testbench/spl_link_tb_top.sv ----
// Purpose: Self-checking bench of the programming link and lock
// Assumes: Short access window and short bit period to keep the run brief
// Notes:   Memory strobes and read answers are checked through a queue
`timescale 1ns/1ps
`default_nettype none
module spl_link_tb_top;
  // ----------------------------------------
  // Signals, design and controller
  // ----------------------------------------
  localparam int          TO   = 20000;
  localparam logic [29:0] CODE = 30'h1b2d4c69; // Arbitrary value
  logic        clk_sys, srst, vlsd, ovh, ovl, sent, nout, lsdis, ovsel, wlock;
  logic        out_o, out_oe, lsdf, ovf, we, re, unl, expd, vman, ppulse, rdone;
  logic [5:0]  maddr, a;
  logic [31:0] rdata, wdata, rw, d;
  logic [39:0] expq[$];
  logic [3:0]  e;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  spl_link #(.ACC_TIMEOUT_CYC(TO), .ACCESS_CODE(CODE)) dut (
    .clk_sys(clk_sys), .srst(srst), .ce(1'b1), .vcc_man_in(vman), .prog_pulse_in(ppulse),
    .low_supply_detect(vlsd), .ov_high_in(ovh), .ov_low_in(ovl), .sent_mode(sent), .norm_out(nout),
    .low_supply_detect_disable(lsdis), .overvoltage_level_low_select(ovsel), .permanent_write_lock(wlock),
    .mem_rdata(rdata), .out_o(out_o), .out_oe(out_oe), .sent_lsd_flag(lsdf), .sent_ov_flag(ovf),
    .mem_addr(maddr), .mem_wdata(wdata), .mem_we(we), .mem_re(re), .unlocked(unl), .access_expired(expd));
  spl_ctl_model m (
    .clk_sys(clk_sys), .out_o(out_o), .vcc_man(vman), .prog_pulse(ppulse), .rd_word(rw), .rd_done(rdone));
  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Compare and count
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Power cycle with a chosen write-lock bit
  task automatic pwr(input logic lk);
    wlock <= lk;
    srst <= 1'b1;
    repeat (16) @(posedge clk_sys);
    chk(40'({out_oe, unl, expd}), 40'h0);
    srst <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
  // Each memory strobe or read answer takes the oldest note
  always @(posedge clk_sys) begin
    if (we === 1'b1 || re === 1'b1 || rdone === 1'b1) begin
      chk(we ? {2'h1, maddr, wdata} : re ? {2'h2, maddr, 32'h0} : {2'h3, 6'h0, rw},
          expq.size() > 0 ? expq.pop_front() : 40'hffffffffff);
    end
  end
  // Hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc > 60000) begin
      num_errors++;
      final_report();
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    {srst, vlsd, ovh, ovl, sent, nout, lsdis, ovsel, wlock} = 9'h100;
    rdata = 32'h0;
    void'($urandom(32'h9c657223));
    pwr(1'b0);
    // Locked: read, disable and a bad-CRC code are all ignored
    m.send(3'h0, 6'h05, 32'h0, 1'b0);
    m.send(3'h2, 6'h00, 32'h0, 1'b0);
    chk(40'(out_oe), 40'h1);
    m.send(3'h1, 6'h24, {2'h0, CODE}, 1'b1);
    chk(40'(unl), 40'h0);
    m.send(3'h1, 6'h24, {2'h0, CODE}, 1'b0);
    chk(40'({unl, expd}), 40'h2);
    // Write commits after two pulses, output released while waiting
    d = $urandom;
    a = 6'($urandom_range(35, 0));
    m.send(3'h1, a, d, 1'b0);
    chk(40'(out_oe), 40'h0);
    expq.push_back({2'h1, a, d});
    m.pulses();
    // Read at another bit rate, output held low before the answer
    d = $urandom;
    rdata <= d;
    expq.push_back({2'h2, a, 32'h0});
    expq.push_back({2'h3, 6'h0, d});
    m.per = 96;
    m.send(3'h0, a, 32'h0, 1'b0);
    chk(40'({out_oe, out_o}), 40'h2);
    m.getans();
    m.per = 64;
    // Output disable and enable commands
    m.send(3'h2, 6'h00, 32'h0, 1'b0);
    chk(40'(out_oe), 40'h0);
    m.send(3'h3, 6'h00, 32'h0, 1'b0);
    chk(40'(out_oe), 40'h1);
    // Supply overrides over every mode and select combination
    for (int i = 0; i < 32; i++) begin
      {sent, lsdis, ovsel, vlsd, ovh} <= 5'(i);
      ovl <= ~ovh;
      nout <= 1'($urandom);
      repeat (6) @(posedge clk_sys);
      e[3] = sent & vlsd & !lsdis;
      e[2] = sent & (ovsel ? ovl : ovh);
      e[1] = 1'b1;
      e[0] = (!sent & ((vlsd & !lsdis) | (ovsel ? ovl : ovh))) ? 1'b0 : nout;
      chk(40'({lsdf, ovf, out_oe, out_o}), 40'(e));
    end
    // Missed window blocks the session; new session re-arms the lock
    pwr(1'b0);
    repeat (TO + 100) @(posedge clk_sys);
    m.send(3'h1, 6'h24, {2'h0, CODE}, 1'b0);
    chk(40'({unl, expd}), 40'h1);
    // Write lock refuses access-code unlocking
    pwr(1'b1);
    m.send(3'h1, 6'h24, {2'h0, CODE}, 1'b0);
    chk(40'({unl, expd}), 40'h0);
    chk(40'(expq.size()), 40'h0);
    final_report();
  end
endmodule
`default_nettype wire
